// ===== common/adc_conv_pkg.sv
package adc_conv_pkg;

	// Timing of the internal conversion
	localparam int CLK_PERIOD_NS = 50;                  // Core clock period
	localparam int CONV_TIME_NS  = 3600;                // Full conversion time
	localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CNT_W    = 7;                   // Holds CONV_CYCLES - 1

	// Word sizes on the serial link
	localparam int RESULT_BITS = 12;                    // Conversion result
	localparam int CFG_BITS    = 16;                    // Configuration word
	localparam int WORD_BITS   = RESULT_BITS + CFG_BITS; // Result plus readback
	localparam int BIT_CNT_W   = 5;                     // Counts up to WORD_BITS

	// Result buffer between converter core and output register
	localparam int FIFO_DEPTH = 32;

	// Configuration word values
	localparam logic [1:0]  LOAD_PATTERN = 2'h3;        // Qualifier that allows an update
	localparam logic [15:0] CFG_RESET    = 16'h0200;    // Continuous operation, no readback

	// Configuration word layout, MSB first
	typedef struct packed {
		logic [1:0] load;                               // Load qualifier bits
		logic [2:0] channel;                            // Input channel select
		logic [1:0] power_mode;                         // Power management
		logic       spare_hi;                           // Unused
		logic       readback;                           // Register readback enable
		logic [6:0] spare_lo;                           // Unused
	} cfg_t;

	// Output word: result followed by the settings that produced it
	typedef struct packed {
		logic [11:0] result;
		cfg_t        cfg;
	} out_word_t;

	// Device states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ  = 2'b01,
		ST_CONV = 2'b10
	} state_t;

endpackage

// ===== src/sample_fifo.sv
`timescale 1ns/1ns
module sample_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = adc_conv_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Filling side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// Draining side
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];                      // Storage
	logic [PTR_W-1:0] wr_ptr_q;                         // Next slot to write
	logic [PTR_W-1:0] rd_ptr_q;                         // Oldest word
	logic [CNT_W-1:0] count_q;                          // Words held
	logic             push;
	logic             pop;

	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_valid_o = (count_q != '0);
	assign out_data_o  = mem[rd_ptr_q];

	// Storage write, no reset needed for data
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data_i;
	end

	// Pointers wrap at DEPTH
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
		end
	end

	// Fill level and a registered ready, so back-pressure is glitch free
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count_q    <= '0;
			in_ready_o <= 1'b1;
		end
		else
		begin
			count_q    <= count_q + CNT_W'(push) - CNT_W'(pop);
			in_ready_o <= (count_q + CNT_W'(push) - CNT_W'(pop)) != CNT_W'(DEPTH);
		end
	end

endmodule // sample_fifo

// ===== src/adc_serial_conversion_interface.sv
`timescale 1ns/1ns
// Behaviour
// (RQ1) Idle fall starts acquisition, rise starts conversion
// (RQ2) Capture serial input on clock rise, control low
// (RQ3) Update serial output on serial clock falls
// (RQ4) Output floats whenever control line is high
// (RQ5) Host keeps serial clock low while control high
// (RQ6) Shift previous result; new settings apply later
// (RQ7) Host stops link activity after data window
// (RQ8) Host reads before conversion ends, else overwritten
// (RQ9) Read timing chosen only by signal timing
// (RQ10) Idle fall drives output high, waits clock
// (RQ11) Read-after: rise after transfer and acquisition time
// (RQ12) Read-after without flag: hold high conversion time
// (RQ13) Other modes: wait conversion time before falling
// (RQ14) Read-during: short pulse, then exchange during conversion
// (RQ15) Read-during: control low at end enables flag
// (RQ16) Spanning: pulse suspends output, fall restores it
// (RQ17) Spanning: control low at end enables flag
// (RQ18) Read-after flag: output high, then low at end
// (RQ19) Falling output after conversion marks completion
// (RQ20) Read-after flag: extra control pulse leaves idle
// (RQ21) Read-during flag: extra clock floats output first
// (RQ22) Spanning flag: extra clock floats, then idle
// (RQ23) Conversion may start after any clock count
// (RQ24) Results leave most significant bit first
// (RQ25) Settings load only with qualifier bits 11
// (RQ26) Readback adds settings word, 28 clocks total
// (RQ27) Reset gives idle with floating output
module adc_serial_conversion_interface (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Serial link pins
	input  wire logic        conversion_control_i,
	input  wire logic        sclk_i,
	input  wire logic        sdi_i,
	output logic             sdo_o,
	output logic             sdo_oe_o,
	// Converter core side
	input  wire logic [11:0] sample_i,
	input  wire logic        sample_valid_i,
	output logic             sample_ready_o,
	output logic             conv_start_o,
	output logic [2:0]       channel_o,
	output logic [1:0]       power_mode_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	adc_conv_pkg::state_t                      state_q;       // Idle, acquisition, conversion
	logic [2:0]                                pin_meta_q;    // First sync stage
	logic [2:0]                                pin_sync_q;    // Second sync stage
	logic [2:0]                                pin_last_q;    // Delayed copy for edges
	logic                                      cnv_s;         // Synced control line
	logic                                      sdi_s;         // Synced serial input
	logic                                      cnv_fall;
	logic                                      cnv_rise;
	logic                                      sclk_rise;
	logic                                      sclk_fall;
	logic [adc_conv_pkg::CONV_CNT_W-1:0]       conv_cnt_q;    // Cycles left in conversion
	logic                                      conv_end;      // Timer expired
	logic                                      conv_done;     // Result taken from buffer
	logic                                      start_conv;
	logic [15:0]                               in_shift_q;    // Incoming settings
	logic [adc_conv_pkg::BIT_CNT_W-1:0]        in_cnt_q;      // Bits captured
	logic                                      capture;
	adc_conv_pkg::cfg_t                        in_word;       // Word on the 16th bit
	logic [adc_conv_pkg::BIT_CNT_W-1:0]        out_cnt_q;     // Bits presented
	logic                                      out_done;      // Whole word shifted
	logic                                      float_q;       // Floated by extra clock
	logic                                      sdo_q;
	logic                                      sdo_oe_q;
	adc_conv_pkg::cfg_t                        pending_cfg_q; // Last accepted settings
	adc_conv_pkg::cfg_t                        active_cfg_q;  // Settings for next start
	adc_conv_pkg::cfg_t                        used_cfg_q;    // Settings of this conversion
	adc_conv_pkg::out_word_t                   out_word_q;    // Word being read out
	logic [11:0]                               fifo_data;
	logic                                      fifo_valid;
	logic                                      fifo_ready;
	logic                                      conv_start_q;

	// Number of bits in the read-out word for a given setting
	function automatic logic [adc_conv_pkg::BIT_CNT_W-1:0] word_len(
		input adc_conv_pkg::cfg_t cfg
	);
		word_len = cfg.readback ? adc_conv_pkg::BIT_CNT_W'(adc_conv_pkg::WORD_BITS)
		                        : adc_conv_pkg::BIT_CNT_W'(adc_conv_pkg::RESULT_BITS);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the first stage feeds only the second

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta_q <= 3'h1;
			pin_sync_q <= 3'h1;
			pin_last_q <= 3'h1;
		end
		else
		begin
			pin_meta_q <= {sclk_i, sdi_i, conversion_control_i};
			pin_sync_q <= pin_meta_q;
			pin_last_q <= pin_sync_q;
		end
	end

	assign cnv_s     = pin_sync_q[0];
	assign sdi_s     = pin_sync_q[1];
	assign cnv_fall  = pin_last_q[0] && !pin_sync_q[0];
	assign cnv_rise  = !pin_last_q[0] && pin_sync_q[0];
	assign sclk_rise = !pin_last_q[2] && pin_sync_q[2];
	assign sclk_fall = pin_last_q[2] && !pin_sync_q[2];

	////////////////////////////////////////////////////////////////////////////////
	// State sequence

	assign start_conv = (state_q == adc_conv_pkg::ST_ACQ) && cnv_rise;
	assign conv_end   = (state_q == adc_conv_pkg::ST_CONV) && (conv_cnt_q == '0);
	assign fifo_ready = conv_end;
	// A late core stalls completion instead of losing a result
	assign conv_done  = conv_end && fifo_valid;

	// Mode is never stored: only edges and the conversion end move the state (see RQ9)
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= adc_conv_pkg::ST_IDLE;               // see RQ27
		else
		begin
			case (state_q)
				adc_conv_pkg::ST_IDLE:
					if (cnv_fall)
						state_q <= adc_conv_pkg::ST_ACQ;        // see RQ1
				adc_conv_pkg::ST_ACQ:
					// Any number of clocks may precede the start
					if (cnv_rise)
						state_q <= adc_conv_pkg::ST_CONV;       // see RQ1 see RQ23
				adc_conv_pkg::ST_CONV:
					if (conv_done)
						state_q <= adc_conv_pkg::ST_IDLE;       // see RQ22
				default:
					state_q <= adc_conv_pkg::ST_IDLE;
			endcase
		end
	end

	// Conversion timer; later control pulses during conversion are ignored
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			conv_cnt_q <= '0;
		else if (start_conv)
			conv_cnt_q <= adc_conv_pkg::CONV_CNT_W'(adc_conv_pkg::CONV_CYCLES - 1);
		else if ((state_q == adc_conv_pkg::ST_CONV) && (conv_cnt_q != '0))
			conv_cnt_q <= conv_cnt_q - 1'b1;
	end

	// One-cycle start strobe to the core
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			conv_start_q <= 1'b0;
		else
			conv_start_q <= start_conv;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Settings input

	// Host keeps the clock quiet while the line is high, so no capture then
	assign capture = !cnv_s && sclk_rise && (state_q != adc_conv_pkg::ST_IDLE)
	                 && (in_cnt_q < adc_conv_pkg::BIT_CNT_W'(adc_conv_pkg::CFG_BITS)); // see RQ5
	assign in_word = {in_shift_q[14:0], sdi_s};

	// Shift register and bit count; restarts with each acquisition
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			in_shift_q <= '0;
			in_cnt_q   <= '0;
		end
		else if ((state_q == adc_conv_pkg::ST_IDLE) && cnv_fall)
			in_cnt_q <= '0;
		else if (capture)
		begin
			in_shift_q <= in_word;                          // see RQ2
			in_cnt_q   <= in_cnt_q + 1'b1;
		end
	end

	// Accept a full word only with the qualifier set
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pending_cfg_q <= adc_conv_pkg::CFG_RESET;
		else if (capture && (in_cnt_q == adc_conv_pkg::BIT_CNT_W'(adc_conv_pkg::CFG_BITS - 1))
		         && (in_word.load == adc_conv_pkg::LOAD_PATTERN))
			pending_cfg_q <= in_word;                       // see RQ25
	end

	// Settings pipeline: new words act only after a conversion has ended
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			active_cfg_q <= adc_conv_pkg::CFG_RESET;
			used_cfg_q   <= adc_conv_pkg::CFG_RESET;
		end
		else
		begin
			if (start_conv)
				used_cfg_q <= active_cfg_q;                 // see RQ6
			if (conv_done)
				active_cfg_q <= pending_cfg_q;              // see RQ6
		end
	end

	// Result register; an unread word is lost here by design
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			out_word_q <= {12'h000, adc_conv_pkg::CFG_RESET};
		else if (conv_done)
			out_word_q <= {fifo_data, used_cfg_q};          // see RQ6 see RQ8
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result output

	assign out_done = (out_cnt_q >= word_len(out_word_q.cfg)); // see RQ26

	// Bits presented; held across a conversion pulse so spanning reads resume
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			out_cnt_q <= '0;
		else if ((state_q == adc_conv_pkg::ST_IDLE) && cnv_fall)
			out_cnt_q <= '0;
		else if (!cnv_s && sclk_fall && (state_q != adc_conv_pkg::ST_IDLE) && !out_done)
			out_cnt_q <= out_cnt_q + 1'b1;                  // see RQ16
	end

	// Extra clock after the word during conversion floats the output until the flag
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			float_q <= 1'b0;
		else if ((state_q == adc_conv_pkg::ST_IDLE) && cnv_fall)
			float_q <= 1'b0;
		else if ((state_q == adc_conv_pkg::ST_CONV) && !cnv_s && sclk_fall && out_done)
			float_q <= 1'b1;                                // see RQ21 see RQ22
	end

	// Output pin; data value is kept while floating so it can be restored
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sdo_q    <= 1'b1;
			sdo_oe_q <= 1'b0;                               // see RQ27
		end
		else if (cnv_s)
			sdo_oe_q <= 1'b0;                               // see RQ4
		else
		begin
			case (state_q)
				adc_conv_pkg::ST_IDLE:
					if (cnv_fall)
					begin
						sdo_q    <= 1'b1;                   // see RQ10
						sdo_oe_q <= 1'b1;
					end
				adc_conv_pkg::ST_ACQ:
					if (sclk_fall && !out_done)
						sdo_q <= out_word_q[5'(adc_conv_pkg::WORD_BITS - 1) - out_cnt_q]; // see RQ3 see RQ24
				adc_conv_pkg::ST_CONV:
					if (conv_done)
					begin
						// Line still low at the end: flag completion
						sdo_q    <= 1'b0;                   // see RQ15 see RQ17 see RQ19
						sdo_oe_q <= 1'b1;
					end
					else if (cnv_fall)
					begin
						if (out_done)
							sdo_q <= 1'b1;                  // see RQ18
						sdo_oe_q <= !float_q;               // see RQ14 see RQ16
					end
					else if (sclk_fall)
					begin
						if (!out_done)
							sdo_q <= out_word_q[5'(adc_conv_pkg::WORD_BITS - 1) - out_cnt_q]; // see RQ3
						else
							sdo_oe_q <= 1'b0;               // see RQ21
					end
				default:
					sdo_oe_q <= 1'b0;
			endcase
		end
	end

	assign sdo_o          = sdo_q;
	assign sdo_oe_o       = sdo_oe_q;
	assign conv_start_o   = conv_start_q;
	assign channel_o      = used_cfg_q.channel;
	assign power_mode_o   = used_cfg_q.power_mode;

	////////////////////////////////////////////////////////////////////////////////
	// Result buffer from the converter core

	sample_fifo #(
		.WIDTH (adc_conv_pkg::RESULT_BITS),
		.DEPTH (adc_conv_pkg::FIFO_DEPTH)
	) u_result_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   (sample_i),
		.in_valid_i  (sample_valid_i),
		.in_ready_o  (sample_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_ready)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_float_cnv_high: assert property (cnv_s |=> !sdo_oe_q) // see RQ4
		else $error("output driven while control line high");

	a_idle_to_acq: assert property (
		(state_q == adc_conv_pkg::ST_IDLE) && cnv_fall |=> (state_q == adc_conv_pkg::ST_ACQ)
		&& sdo_oe_q && sdo_q) // see RQ1 see RQ10
		else $error("idle fall did not start acquisition with output high");

	a_acq_to_conv: assert property (
		start_conv |=> (state_q == adc_conv_pkg::ST_CONV) ##1 (state_q == adc_conv_pkg::ST_CONV)
		[*8]) // see RQ1 see RQ23
		else $error("conversion did not start or ended too early");

	a_conv_length: assert property (
		start_conv |=> (conv_cnt_q == 7'h47) ##71 (conv_cnt_q == 7'h00)) // see RQ1
		else $error("conversion time wrong");

	a_sdi_capture: assert property (
		capture |=> (in_shift_q[0] == $past(sdi_s)) && (in_cnt_q == $past(in_cnt_q) + 1'b1)) // see RQ2
		else $error("serial input bit not captured");

	a_load_gate: assert property (
		capture && (in_word.load != adc_conv_pkg::LOAD_PATTERN) |=> $stable(pending_cfg_q)) // see RQ25
		else $error("settings changed without qualifier");

	a_sdo_on_fall: assert property (
		(state_q == adc_conv_pkg::ST_ACQ) && sdo_oe_q && !cnv_s && !sclk_fall
		|=> $stable(sdo_q)) // see RQ3
		else $error("output changed without a serial clock fall");

	a_eoc_flag: assert property (
		conv_done && !cnv_s |=> sdo_oe_q && !sdo_q && (state_q == adc_conv_pkg::ST_IDLE)) // see RQ19
		else $error("end of conversion not flagged");

	a_float_extra: assert property (
		(state_q == adc_conv_pkg::ST_CONV) && !cnv_s && sclk_fall && out_done && !conv_done
		|=> !sdo_oe_q) // see RQ21
		else $error("extra clock did not float output");

	a_cfg_order: assert property (
		conv_done |=> (out_word_q.cfg == $past(used_cfg_q))
		&& (active_cfg_q == $past(pending_cfg_q))) // see RQ6
		else $error("settings pipeline out of order");

	c_eoc_seen: cover property (conv_done && !cnv_s);
	c_no_eoc: cover property (conv_done && cnv_s);
	c_span_resume: cover property ((state_q == adc_conv_pkg::ST_CONV) && cnv_fall
		&& (out_cnt_q != '0) && !out_done);
	c_cfg_loaded: cover property (capture && (in_word.load == adc_conv_pkg::LOAD_PATTERN)
		&& (in_cnt_q == 5'h0f));

endmodule // adc_serial_conversion_interface

// ===== dv/adc_host_model.sv
`timescale 1ns/1ns
module adc_host_model (
	// Clock
	input  wire logic clk_i,
	// Pins toward the device
	output logic      cc_o,
	output logic      sclk_o,
	output logic      sdi_o,
	// Data wire from the device
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i
);
	logic tog;  // Flips each cycle so a floating wire never looks stable
	logic line; // Level seen on the data wire

	// Pins start with the control line high and the serial clock low
	initial
	begin
		cc_o   = 1'b1;
		sclk_o = 1'b0;
		sdi_o  = 1'b0;
		tog    = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// The wire has no pull, so an undriven wire must not repeat the last bit
	always @(posedge clk_i)
		tog <= ~tog;
	assign line = sdo_oe_i ? sdo_i : tog;

	////////////////////////////////////////////////////////////////////////
	// Wait a number of core cycles
	task wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Move the control line; the serial clock is kept low meanwhile
	task ctl(input logic v, input logic d);
		@(posedge clk_i);
		cc_o   <= v;
		sclk_o <= 1'b0;
		sdi_o  <= d;
	endtask

	// One 8-cycle serial period; returns the bit shown by the previous fall
	task cyc(input logic din, output logic dout);
		@(posedge clk_i);
		sclk_o <= 1'b1;
		@(negedge clk_i);
		dout = line;
		repeat (4) @(posedge clk_i);
		sclk_o <= 1'b0;
		sdi_o  <= din;
		repeat (3) @(posedge clk_i);
	endtask

	// Bit shown by the last fall, read once it has settled
	task tail(output logic dout);
		@(posedge clk_i);
		@(negedge clk_i);
		dout = line;
	endtask
endmodule // adc_host_model

// ===== dv/tb_adc_serial_conversion_interface.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			fails++; \
			$display("wrong value %s: expected %h, seen %h", nm, e, g); \
		end \
	end

module tb_adc_serial_conversion_interface;
	// Clock, reset and pins
	logic        clk_i;
	logic        rst_n_i;
	logic        cc;
	logic        sclk;
	logic        sdi;
	logic        sdo_o;
	logic        sdo_oe_o;
	// Converter core side
	logic [11:0] sample_i;
	logic        sample_valid_i;
	logic        sample_ready_o;
	logic        conv_start_o;
	logic [2:0]  channel_o;
	logic [1:0]  power_mode_o;
	// Counters and reference model
	int          fails;
	int          n_tests;
	int          starts;   // Conversion starts seen
	logic [31:0] rng;      // Xorshift state
	logic [11:0] q[$];     // Words taken by the buffer, oldest first
	logic [15:0] act;      // Settings for the next start
	logic [15:0] pend;     // Accepted word waiting for a conversion end
	logic [15:0] used;     // Settings of the running conversion
	logic [27:0] exp_w;    // Word the next read should show
	logic        have_exp; // Output register content is known
	int          outlen;   // Bits in that word

	// 20 MHz core clock
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	adc_serial_conversion_interface uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .conversion_control_i(cc), .sclk_i(sclk),
		.sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sample_i(sample_i),
		.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
		.conv_start_o(conv_start_o), .channel_o(channel_o), .power_mode_o(power_mode_o)
	);

	adc_host_model host (
		.clk_i(clk_i), .cc_o(cc), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo_o),
		.sdo_oe_i(sdo_oe_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Seeded pseudo-random source
	function logic [31:0] next_rand();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// Record buffer pushes and conversion starts from pre-edge values
	always @(posedge clk_i)
	begin
		if (sample_valid_i && sample_ready_o)
			q.push_back(sample_i);
		if (conv_start_o)
			starts++;
	end

	// Verdict and end of run
	task stop_test();
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Bounded wait for the end-of-conversion low level
	task automatic wait_flag();
		int c;
		c = 0;
		while (!(sdo_oe_o === 1'b1 && sdo_o === 1'b0) && c < 120)
		begin
			host.wt(1);
			c++;
		end
		`CHK("end flag", 2'b10, {sdo_oe_o, sdo_o})
	endtask

	// Start a conversion; short pulse unless the host holds the line high
	task automatic start_conv(input int m, input logic [15:0] w);
		if (w[15:14] == 2'b11)
			pend = w;
		used = act;
		host.ctl(1'b1, 1'(next_rand()));
		host.wt(6);
		`CHK("float while high", 1'b0, sdo_oe_o)
		`CHK("channel", used[13:11], channel_o)
		`CHK("power mode", used[10:9], power_mode_o)
		if (m == 0)
			host.wt(90);
		else
		begin
			host.ctl(1'b0, 1'(next_rand()));
			host.wt(8);
		end
		if (m == 1)
			`CHK("busy level", 2'b11, {sdo_oe_o, sdo_o})
	endtask

	// One frame: 0 after, 1 after with flag, 2 spanning with flag, 3 spanning
	task automatic frame(input int m);
		int          n;
		int          k;
		int          i;
		logic [31:0] r;
		logic [15:0] w;
		logic        d;
		logic [27:0] got;
		r = next_rand();
		w = r[15:0];
		if (r[16])
			w[15:14] = 2'b11;
		if (m > 1)
			w = 16'h0000;
		n = (m > 1 || outlen > 16) ? outlen : 16;
		k = (m > 1) ? n - 4 : n;
		got = '0;
		host.ctl(1'b0, w[15]);
		host.wt(8);
		`CHK("entry level", 2'b11, {sdo_oe_o, sdo_o})
		for (i = 0; i <= n; i++)
		begin
			if (i == k || i == n)
			begin
				host.tail(d);
				got = {got[26:0], d};
			end
			if (i == k)
				start_conv(m, w);
			if (i < n)
			begin
				host.cyc((i < 15) ? w[14 - i] : 1'(next_rand()), d);
				if (i == k)
					`CHK("resumed bit", got[0], d)
				else if (i > 0)
					got = {got[26:0], d};
			end
		end
		if (have_exp)
			`CHK("result", exp_w[27:16], got[n - 1 -: 12])
		if (have_exp && outlen == 28)
			`CHK("readback", exp_w[15:0], got[15:0])
		if (m == 2)
		begin
			host.cyc(1'(next_rand()), d);
			host.tail(d);
			`CHK("float after extra", 1'b0, sdo_oe_o)
		end
		if (m == 1 || m == 2)
			wait_flag();
		host.ctl(1'b1, 1'(next_rand()));
		if (m == 3)
		begin
			host.wt(80);
			`CHK("no flag", 1'b0, sdo_oe_o)
		end
		host.wt(6);
		act = pend;
		exp_w = {q.pop_front(), used};
		outlen = used[7] ? 28 : 12;
		have_exp = 1'b1;
		$display("test frame mode %0d done", m);
	endtask

	// Hang guard
	initial
	begin
		repeat (30000) @(posedge clk_i);
		fails++;
		$display("watchdog expired");
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		int f;
		rst_n_i = 1'b0;
		sample_i = 12'h000;
		sample_valid_i = 1'b0;
		fails = 0;
		n_tests = 0;
		starts = 0;
		rng = 32'h0000_0007;
		act = 16'h0200;
		pend = 16'h0200;
		have_exp = 1'b0;
		outlen = 12;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		host.wt(2);
		`CHK("reset pins", 2'b10, {sdo_o, conv_start_o})
		`CHK("reset float", 1'b0, sdo_oe_o)
		`CHK("reset channel", 3'h0, channel_o)
		`CHK("reset power", 2'h1, power_mode_o)
		`CHK("reset ready", 1'b1, sample_ready_o)
		$display("test reset done");
		// Offer more words than fit; the buffer must refuse the rest
		for (f = 0; f <= 40; f++)
		begin
			@(posedge clk_i);
			sample_valid_i <= (f < 40);
			sample_i <= 12'(next_rand());
		end
		host.wt(2);
		`CHK("buffer fill", 32, q.size())
		`CHK("full ready", 1'b0, sample_ready_o)
		$display("test buffer fill done");
		// Timing alone picks the read style; each frame drains one word
		for (f = 0; f < 32; f++)
			frame(f % 4);
		`CHK("starts", 32, starts)
		`CHK("drained ready", 1'b1, sample_ready_o)
		$display("test drain done");
		stop_test();
	end
endmodule // tb_adc_serial_conversion_interface
